// File: sec_params.svh
// constants for the serial eeprom command and status core
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH
`define SEC_OP_STATUS_WRITE 8'h01
`define SEC_OP_PAGE_WRITE   8'h02
`define SEC_OP_ARRAY_READ   8'h03
`define SEC_OP_CLEAR_LATCH  8'h04
`define SEC_OP_STATUS_READ  8'h05
`define SEC_OP_SET_LATCH    8'h06
`define SEC_ADDR_W          13
`define SEC_PAGE_W          5
`define SEC_PAGE_LAST       5'h1f
`define SEC_PROT_L1_BASE    13'h1800
`define SEC_PROT_L2_BASE    13'h1000
`define SEC_RSV_VAL         3'h0
`define SEC_BP_INIT         2'h0
`define SEC_LOCK_INIT       1'b0
`define SEC_TWC_MS          10
`define SEC_CLK_MHZ         100
`endif

// File: sec_pkg.sv
// types shared by the serial eeprom core
package sec_pkg;
  typedef enum logic [3:0] {
    ST_CMD, ST_ADDR_HI, ST_ADDR_LO, ST_READ, ST_STAT_RD, ST_STAT_WR,
    ST_STAT_WR_END, ST_SET_END, ST_CLR_END, ST_PAGE, ST_IGNORE
  } sec_state_t;
  typedef enum logic [1:0] {WE_IDLE, WE_WAIT, WE_COPY} sec_wr_t;
  typedef struct packed {
    logic       lock;
    logic [2:0] rsv;
    logic [1:0] bp;
    logic       wel;
    logic       busy;
  } sec_status_t;
endpackage

// File: sec_two_buf.sv
// two-entry valid/ready buffer with synchronous flush
`timescale 1ns/10ps
module sec_two_buf #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_flush,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  logic [W-1:0] mem_ff [2];
  logic         wr_ff;
  logic         rd_ff;
  logic [1:0]   cnt_ff;
  logic [1:0]   nxt_cnt;
  wire          push = i_in_valid & o_in_ready;
  wire          pop  = o_out_valid & i_out_ready;

  assign o_in_ready  = (cnt_ff != 2'h2);
  assign o_out_valid = (cnt_ff != 2'h0);
  assign o_out_data  = mem_ff[rd_ff];
  assign nxt_cnt     = cnt_ff + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge i_clk)
  begin
    if (i_srst | i_flush)
    begin
      wr_ff  <= 1'b0;
      rd_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      wr_ff  <= wr_ff ^ push;
      rd_ff  <= rd_ff ^ pop;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage needs no reset, the count guards it
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_ff[wr_ff] <= i_in_data;
  end
endmodule

// File: sec_eeprom_core.sv
// serial eeprom command decoder, read path, status and write engine
// Notes on behaviour
// RQ1: opcode 06h alone sets the write-enable latch.
// RQ2: opcode 04h alone clears the write-enable latch.
// RQ3: read is 03h plus 16-bit address high first, then data shifts out.
// RQ4: read address increments per byte and wraps from top to zero.
// RQ5: chip select high ends the frame; output released while deselected.
// RQ6: top three address bits are ignored, 13 bits select a byte.
// RQ7: sample on rising clock through clock 23, drive from falling 23, msb first.
// RQ8: status byte shifts out from falling edge after eighth opcode bit, bit 7 first.
// RQ9: continued clocking repeats the status byte from bit 7.
// RQ10: status read is answered at any time, even while busy.
// RQ11: status layout busy, latch, protect level, zero reserved, lock.
// RQ12: busy reads one during internal write, zero after.
// RQ13: protect level and lock survive reset; busy, latch, reserved start zero.
// RQ14: status write is 01h plus one byte, started at chip select rise.
// RQ15: status write changes only bits 2, 3 and 7.
// RQ16: host raises write-protect pin and sets latch before status write.
// RQ17: host polls busy with status reads to see completion.
// RQ18: latch zero blocks every write; latch one allows unprotected writes.
// RQ19: latch clears at power-on and when any internal write completes.
// RQ20: unexecuted write or any read leaves the latch unchanged.
// RQ21: page write is 02h, two address bytes, 1 to 32 data bytes.
// RQ22: protect level selects the write-protected array region.
// RQ23: levels none, 1800h-1FFFh, 1000h-1FFFh, whole array.
// RQ24: lock with write-protect pin low ignores status writes.
// RQ25: page offset wraps within page; only the last 32 bytes are kept.
// RQ26: write not ending on a whole byte before chip select rise is dropped.
// RQ27: mode 0 and mode 3 behave alike, whatever the idle clock level.
// RQ28: unknown opcode is ignored with output released until deselect.
`timescale 1ns/10ps
`include "sec_params.svh"
module sec_eeprom_core #(
  parameter int unsigned WR_CYCLES = `SEC_TWC_MS * 1000 * `SEC_CLK_MHZ
) (
  input  wire logic I_CLK,
  input  wire logic I_SRST,
  input  wire logic I_CS_N,
  input  wire logic I_SCK,
  input  wire logic I_SI,
  input  wire logic I_WP_N,
  output logic      O_SO,
  output logic      O_SO_OE
);
  import sec_pkg::*;

  localparam int AW    = `SEC_ADDR_W;
  localparam int PW    = `SEC_PAGE_W;
  localparam int BYTES = 1 << AW;
  localparam int PAGE  = 1 << PW;

  // pin synchronisers
  logic [1:0]    cs_sync_ff;
  logic [1:0]    sck_sync_ff;
  logic [1:0]    si_sync_ff;
  logic [1:0]    wp_sync_ff;
  logic          cs_d_ff;
  logic          sck_d_ff;

  // frame state
  sec_state_t    state_ff;
  sec_state_t    nxt_state;
  logic [2:0]    bit_ff;
  logic [6:0]    shin_ff;
  logic [7:0]    op_ff;
  logic [AW-1:0] addr_ff;

  // output shifter
  logic          so_ff;
  logic          oe_ff;
  logic [6:0]    osh_ff;
  logic [2:0]    obit_ff;

  // status storage; nonvolatile bits are kept out of reset
  logic          wel_ff;
  logic          nxt_wel;
  logic [1:0]    bp_ff = `SEC_BP_INIT;
  logic          lock_ff = `SEC_LOCK_INIT;
  logic [1:0]    pend_bp_ff;
  logic          pend_lock_ff;

  // write engine
  sec_wr_t       we_ff;
  sec_wr_t       nxt_we;
  logic [31:0]   tmr_ff;
  logic          kind_page_ff;
  logic [PW-1:0] cp_ff;
  logic [AW-PW-1:0] pg_base_ff;
  logic [PW-1:0] pg_ptr_ff;
  logic [PAGE-1:0] pg_vld_ff;
  logic [7:0]    pg_mem_ff [PAGE];
  logic [7:0]    mem_ff [BYTES];

  function automatic sec_state_t op_decode(input logic [7:0] op, input logic busy);
    sec_state_t s;
    s = ST_IGNORE;
    case (op)
      `SEC_OP_SET_LATCH:    s = ST_SET_END;
      `SEC_OP_CLEAR_LATCH:  s = ST_CLR_END;
      `SEC_OP_STATUS_READ:  s = ST_STAT_RD;
      `SEC_OP_STATUS_WRITE: s = ST_STAT_WR;
      `SEC_OP_ARRAY_READ:   s = ST_ADDR_HI;
      `SEC_OP_PAGE_WRITE:   s = busy ? ST_IGNORE : ST_ADDR_HI;
      default:              s = ST_IGNORE;
    endcase
    return s;
  endfunction

  function automatic logic is_protected(input logic [AW-1:0] a, input logic [1:0] bp);
    logic p;
    p = 1'b1;
    case (bp)
      2'h0:    p = 1'b0;
      2'h1:    p = (a >= `SEC_PROT_L1_BASE);
      2'h2:    p = (a >= `SEC_PROT_L2_BASE);
      default: p = 1'b1;
    endcase
    return p;
  endfunction

  // edges seen only through the second synchroniser stage
  wire         cs_n      = cs_sync_ff[1];
  wire         sck       = sck_sync_ff[1];
  wire         si        = si_sync_ff[1];
  wire         wp_high   = wp_sync_ff[1];
  wire         sck_rise  = sck & ~sck_d_ff & ~cs_n;  // see RQ27
  wire         sck_fall  = ~sck & sck_d_ff & ~cs_n;  // see RQ27
  wire         cs_rise   = cs_n & ~cs_d_ff;
  wire [7:0]   rx_byte   = {shin_ff, si};
  wire         byte_done = sck_rise & (bit_ff == 3'h7);
  wire         whole     = (bit_ff == 3'h0);         // see RQ26
  wire         busy      = (we_ff != WE_IDLE);
  wire         is_page   = (op_ff == `SEC_OP_PAGE_WRITE);
  wire         in_read   = (state_ff == ST_READ);
  wire         in_stat   = (state_ff == ST_STAT_RD);
  wire         tmr_end   = (tmr_ff == WR_CYCLES - 32'h1);
  wire         cp_end    = (cp_ff == `SEC_PAGE_LAST);

  sec_status_t stat;
  assign stat = '{lock: lock_ff, rsv: `SEC_RSV_VAL, bp: bp_ff, wel: wel_ff, busy: busy};  // see RQ11 RQ12

  // commit decisions; latch set/clear and write starts taken at chip select rise, completions from the write engine
  wire set_wel    = cs_rise & (state_ff == ST_SET_END) & whole;  // see RQ1
  wire clr_wel    = cs_rise & (state_ff == ST_CLR_END) & whole;  // see RQ2
  wire stat_ok    = wel_ff & (wp_high | ~lock_ff) & ~busy;       // see RQ18 RQ24
  wire start_stat = cs_rise & (state_ff == ST_STAT_WR_END) & whole & stat_ok;  // see RQ14
  wire page_ok    = wel_ff & ~busy & (|pg_vld_ff) & ~is_protected(addr_ff, bp_ff);  // see RQ18 RQ22 RQ23
  wire start_page = cs_rise & (state_ff == ST_PAGE) & whole & page_ok;  // see RQ21 RQ26
  wire stat_done  = (we_ff == WE_WAIT) & tmr_end & ~kind_page_ff;
  wire page_done  = (we_ff == WE_COPY) & cp_end;

  // read prefetch into the two-entry buffer
  wire       rbuf_in_ready;
  wire       rbuf_out_valid;
  wire [7:0] rbuf_out_data;
  wire       rbuf_push = in_read & ~cs_n & rbuf_in_ready;
  wire       out_load  = sck_fall & (obit_ff == 3'h0);
  wire       rbuf_pop  = out_load & in_read;
  wire [7:0] out_src   = in_read ? rbuf_out_data : stat;

  sec_two_buf #(
    .W (8)
  ) u_rbuf (
    .i_clk       (I_CLK),
    .i_srst      (I_SRST),
    .i_flush     (cs_n),
    .i_in_valid  (in_read & ~cs_n),
    .o_in_ready  (rbuf_in_ready),
    .i_in_data   (mem_ff[addr_ff]),
    .o_out_valid (rbuf_out_valid),
    .i_out_ready (rbuf_pop),
    .o_out_data  (rbuf_out_data)
  );

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      cs_sync_ff  <= 2'h3;
      sck_sync_ff <= 2'h0;
      si_sync_ff  <= 2'h0;
      wp_sync_ff  <= 2'h0;
      cs_d_ff     <= 1'b1;
      sck_d_ff    <= 1'b0;
    end
    else
    begin
      cs_sync_ff  <= {cs_sync_ff[0], I_CS_N};
      sck_sync_ff <= {sck_sync_ff[0], I_SCK};
      si_sync_ff  <= {si_sync_ff[0], I_SI};
      wp_sync_ff  <= {wp_sync_ff[0], I_WP_N};
      cs_d_ff     <= cs_n;
      sck_d_ff    <= sck;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    if (cs_n)
      nxt_state = ST_CMD;  // see RQ5
    else if (byte_done)
    begin
      case (state_ff)
        ST_CMD:         nxt_state = op_decode(rx_byte, busy);  // see RQ28 RQ10
        ST_ADDR_HI:     nxt_state = ST_ADDR_LO;
        ST_ADDR_LO:     nxt_state = is_page ? ST_PAGE : ST_READ;  // see RQ3
        ST_STAT_WR:     nxt_state = ST_STAT_WR_END;
        // a byte beyond a short command voids it
        ST_STAT_WR_END: nxt_state = ST_IGNORE;
        ST_SET_END:     nxt_state = ST_IGNORE;
        ST_CLR_END:     nxt_state = ST_IGNORE;
        default:        nxt_state = state_ff;
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST | cs_n)
    begin
      state_ff <= ST_CMD;
      bit_ff   <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      bit_ff   <= bit_ff + {2'h0, sck_rise};  // see RQ7
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      shin_ff <= 7'h00;
      op_ff   <= 8'h00;
    end
    else if (sck_rise)
    begin
      shin_ff <= rx_byte[6:0];
      if (byte_done & (state_ff == ST_CMD))
        op_ff <= rx_byte;
    end
  end

  // address register doubles as read pointer
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      addr_ff <= '0;
    else if (byte_done & (state_ff == ST_ADDR_HI))
      addr_ff[AW-1:8] <= rx_byte[AW-9:0];  // see RQ6
    else if (byte_done & (state_ff == ST_ADDR_LO))
      addr_ff[7:0] <= rx_byte;
    else if (rbuf_push)
      addr_ff <= addr_ff + {{(AW-1){1'b0}}, 1'b1};  // see RQ4
  end

  // output shifter, falling edges only
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST | cs_n)
    begin
      so_ff   <= 1'b0;
      oe_ff   <= 1'b0;  // see RQ5
      osh_ff  <= 7'h00;
      obit_ff <= 3'h0;
    end
    else if (sck_fall & (in_read | in_stat))
    begin
      oe_ff   <= 1'b1;
      obit_ff <= obit_ff - 3'h1;
      so_ff   <= out_load ? out_src[7] : osh_ff[6];  // see RQ7 RQ8 RQ9
      osh_ff  <= out_load ? out_src[6:0] : {osh_ff[5:0], 1'b0};
    end
  end

  // page loading; stale entries cleared when a new page write begins
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      pg_ptr_ff <= '0;
      pg_vld_ff <= '0;
    end
    else if (byte_done & (state_ff == ST_ADDR_LO) & is_page)
    begin
      pg_ptr_ff <= rx_byte[PW-1:0];
      pg_vld_ff <= '0;
    end
    else if (byte_done & (state_ff == ST_PAGE))
    begin
      pg_ptr_ff            <= pg_ptr_ff + {{(PW-1){1'b0}}, 1'b1};  // see RQ25
      pg_vld_ff[pg_ptr_ff] <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (byte_done & (state_ff == ST_PAGE))
      pg_mem_ff[pg_ptr_ff] <= rx_byte;  // see RQ25
  end

  always_ff @(posedge I_CLK)
  begin
    if ((we_ff == WE_COPY) & pg_vld_ff[cp_ff])
      mem_ff[{pg_base_ff, cp_ff}] <= pg_mem_ff[cp_ff];
  end

  // pending status bits; bits 0, 1, 4-6 of the data are dropped
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      pend_bp_ff   <= 2'h0;
      pend_lock_ff <= 1'b0;
    end
    else if (byte_done & (state_ff == ST_STAT_WR) & ~busy)
    begin
      pend_bp_ff   <= rx_byte[3:2];  // see RQ15
      pend_lock_ff <= rx_byte[7];
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (stat_done)
    begin
      bp_ff   <= pend_bp_ff;  // see RQ13
      lock_ff <= pend_lock_ff;
    end
  end

  always_comb
  begin
    nxt_we = we_ff;
    case (we_ff)
      WE_IDLE: nxt_we = (start_stat | start_page) ? WE_WAIT : WE_IDLE;
      WE_WAIT: nxt_we = tmr_end ? (kind_page_ff ? WE_COPY : WE_IDLE) : WE_WAIT;
      WE_COPY: nxt_we = cp_end ? WE_IDLE : WE_COPY;
      default: nxt_we = WE_IDLE;
    endcase
  end

  // busy covers the whole wait and the page copy
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      we_ff        <= WE_IDLE;  // see RQ12
      tmr_ff       <= 32'h0;
      cp_ff        <= '0;
      kind_page_ff <= 1'b0;
      pg_base_ff   <= '0;
    end
    else
    begin
      we_ff  <= nxt_we;
      tmr_ff <= (we_ff == WE_WAIT) ? tmr_ff + 32'h1 : 32'h0;
      cp_ff  <= (we_ff == WE_COPY) ? cp_ff + {{(PW-1){1'b0}}, 1'b1} : '0;
      if (we_ff == WE_IDLE)
      begin
        kind_page_ff <= start_page;
        pg_base_ff   <= addr_ff[AW-1:PW];
      end
    end
  end

  // completion clears the latch; a command in the same cycle wins
  always_comb
  begin
    nxt_wel = wel_ff;  // see RQ20
    if (stat_done | page_done)
      nxt_wel = 1'b0;  // see RQ19
    if (set_wel)
      nxt_wel = 1'b1;  // see RQ1
    if (clr_wel)
      nxt_wel = 1'b0;  // see RQ2
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      wel_ff <= 1'b0;  // see RQ19
    else
      wel_ff <= nxt_wel;
  end

  assign O_SO    = so_ff;
  assign O_SO_OE = oe_ff;
endmodule

// File: sec_eeprom_core_asserts.sv
// pin-level assertions for the serial eeprom core
`timescale 1ns/10ps
module sec_eeprom_core_chk (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CS_N,
  input wire logic I_SCK,
  input wire logic I_SI,
  input wire logic I_WP_N,
  input wire logic O_SO,
  input wire logic O_SO_OE
);
  logic        sck_ff;
  logic [15:0] rise_cnt_ff;
  wire         sck_rise = I_SCK & ~sck_ff;
  // raw pin edges, so the count leads the design's synchronised view
  always_ff @(posedge I_CLK)
  begin
    sck_ff      <= I_SCK;
    rise_cnt_ff <= I_CS_N ? 16'h0 : rise_cnt_ff + {15'h0, sck_rise};
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence cs_held_low;
    !I_CS_N [*4];
  endsequence
  sequence drive_starts;
    $rose(O_SO_OE);
  endsequence
  AST_RST_QUIET: assert property ($fell(I_SRST) |-> !O_SO_OE && !O_SO)
    else $error("output active after reset");
  AST_DESEL_IDLE: assert property (I_CS_N [*5] |-> !O_SO_OE)
    else $error("output driven while deselected");
  AST_CS_RELEASE: assert property ($rose(I_CS_N) |-> ##[1:5] !O_SO_OE)
    else $error("output not released");
  AST_DROP_CAUSE: assert property ($fell(O_SO_OE) |-> !O_SO && $past(I_CS_N, 3))
    else $error("output released inside frame");
  AST_FIRST_BIT: assert property (drive_starts |->
    (rise_cnt_ff == 16'h8 || rise_cnt_ff == 16'h18) && !$past(I_SCK, 3))
    else $error("first output bit at wrong clock");
  AST_SILENT: assert property (O_SO_OE && !I_CS_N |-> rise_cnt_ff >= 16'h8)
    else $error("output before opcode done");
  AST_SHIFT_FALL: assert property (O_SO_OE && $past(O_SO_OE) && $changed(O_SO) |->
    !$past(I_SCK, 3))
    else $error("output changed off a falling edge");
  AST_KEEP_DRIVE: assert property (cs_held_low ##0 O_SO_OE |=> O_SO_OE)
    else $error("output stopped inside frame");
endmodule

// File: sec_spi_host.sv
// spi host model that frames commands and gathers reply bytes
`timescale 1ns/10ps
module sec_spi_host (
  input  wire logic  i_clk,
  input  wire logic  i_so,
  input  wire logic  i_so_oe,
  output logic       o_cs_n,
  output logic       o_sck,
  output logic       o_si,
  output logic       o_rx_stb,
  output logic [8:0] o_rx
);
  logic       mode3 = 1'b0;
  logic [7:0] last_b = 8'h0;
  logic [7:0] tx [40];
  initial
  begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_si     = 1'b0;
    o_rx_stb = 1'b0;
    o_rx     = 9'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // nb bytes then xb loose bits; bytes from index post on are reported
  task automatic frame(input int nb, input int post, input int xb = 0);
    logic all;
    o_sck = mode3;
    tick(1);
    o_cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < nb * 8 + xb; i++)
    begin
      o_sck = 1'b0;
      o_si = tx[i / 8][7 - i % 8];
      tick(4);
      all = (i % 8 == 0) ? i_so_oe : all & i_so_oe;
      last_b = {last_b[6:0], i_so & i_so_oe};
      o_sck = 1'b1;
      o_rx = {all, last_b};
      o_rx_stb = (i % 8 == 7 && i / 8 >= post);
      tick(1);
      o_rx_stb = 1'b0;
      tick(3);
    end
    o_sck = mode3;
    tick(4);
    o_cs_n = 1'b1;
    o_si = ~o_si;
    tick(10);
  endtask
  // bounded busy polling by status reads
  task automatic poll_ready(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      tx[0] = 8'h05;
      frame(2, 2);
      ok = (o_rx[8] === 1'b1 && last_b[0] === 1'b0);
    end
  endtask
endmodule

// File: test_sec_eeprom_core.sv
// self-checking bench for the serial eeprom core
`timescale 1ns/10ps
`include "sec_params.svh"
module test_sec_eeprom_core;
  logic       clk;
  logic       srst;
  logic       wp_n;
  logic       ok;
  logic [7:0] op;
  logic [7:0] d [3];
  logic [8:0] exp_q [$];
  int         mismatches = 0;
  int         tests_run = 0;
  int         seed = 32'h6ef5;
  wire        cs_n, sck, si, so, so_oe, rx_stb;
  wire  [8:0] rx;
  always #5 clk = ~clk;
  // short write time keeps busy polling cheap
  sec_eeprom_core #(.WR_CYCLES(1000)) dut (.I_CLK(clk), .I_SRST(srst), .I_CS_N(cs_n),
    .I_SCK(sck), .I_SI(si), .I_WP_N(wp_n), .O_SO(so), .O_SO_OE(so_oe));
  sec_spi_host host (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si), .o_rx_stb(rx_stb), .o_rx(rx));
  always @(posedge clk)
  begin
    if (rx_stb === 1'b1)
    begin
      tests_run++;
      if (exp_q.size() == 0 || exp_q[0] !== rx)
      begin
        mismatches++;
        $display("Error at %0t: got %h expected %h", $time, rx, exp_q.size() ? exp_q[0] : 9'h0);
      end
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
  end
  task automatic complete_run;
    mismatches = mismatches + exp_q.size();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic stat(input logic [7:0] v);
    host.tx[0] = `SEC_OP_STATUS_READ;
    exp_q.push_back({1'b1, v});
    exp_q.push_back({1'b1, v});
    host.frame(3, 1);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] v = 8'h0, input int nb = 1);
    host.tx[0] = c;
    host.tx[1] = v;
    host.frame(nb, 9);
  endtask
  task automatic xfer(input logic [7:0] c, input logic [15:0] a, input int n, input int post, input int o = 0);
    host.tx[0] = c;
    host.tx[1] = a[15:8];
    host.tx[2] = a[7:0];
    for (int i = 0; i < n; i++)
      host.tx[3 + i] = d[o + i];
    host.frame(3 + n, post);
  endtask
  task automatic wait_done;
    host.poll_ready(ok);
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, ok, 1'b1);
      complete_run();
    end
  endtask
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    wp_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    host.tick(5);
    for (int k = 0; k < 3; k++)
      d[k] = 8'($random(seed));
    stat(8'h00);
    cmd(`SEC_OP_SET_LATCH);
    stat(8'h02);
    xfer(`SEC_OP_ARRAY_READ, 16'h0, 1, 9);
    stat(8'h02);
    cmd(`SEC_OP_CLEAR_LATCH);
    stat(8'h00);
    cmd(`SEC_OP_SET_LATCH, 8'h0, 2);
    host.tx[0] = `SEC_OP_SET_LATCH;
    host.frame(1, 9, 1);
    stat(8'h00);
    xfer(`SEC_OP_PAGE_WRITE, 16'h0, 1, 99);
    stat(8'h00);
    $display("latch test done");
    for (int k = 0; k < 6; k++)
    begin
      op = 8'($random(seed));
      if (op inside {[8'h01:8'h06]})
        op = op | 8'h40;
      host.mode3 = k[0];
      exp_q.push_back(9'h0);
      exp_q.push_back(9'h0);
      xfer(op, 16'h0, 0, 1);
    end
    host.mode3 = 1'b0;
    $display("opcode test done");
    cmd(`SEC_OP_SET_LATCH);
    xfer(`SEC_OP_PAGE_WRITE, 16'he01f, 2, 99);
    stat(8'h03);
    wait_done();
    stat(8'h00);
    cmd(`SEC_OP_SET_LATCH);
    xfer(`SEC_OP_PAGE_WRITE, 16'h1fff, 1, 99, 2);
    wait_done();
    host.mode3 = 1'b1;
    exp_q.push_back({1'b1, d[2]});
    exp_q.push_back({1'b1, d[1]});
    xfer(`SEC_OP_ARRAY_READ, 16'hbfff, 2, 3);
    exp_q.push_back({1'b1, d[0]});
    xfer(`SEC_OP_ARRAY_READ, 16'h001f, 1, 3);
    host.mode3 = 1'b0;
    $display("array test done");
    wp_n = 1'b1;
    cmd(`SEC_OP_SET_LATCH);
    cmd(`SEC_OP_STATUS_WRITE, 8'hff, 2);
    wait_done();
    stat(8'h8c);
    wp_n = 1'b0;
    cmd(`SEC_OP_SET_LATCH);
    cmd(`SEC_OP_STATUS_WRITE, 8'h00, 2);
    stat(8'h8e);
    wp_n = 1'b1;
    cmd(`SEC_OP_STATUS_WRITE, 8'h04, 2);
    wait_done();
    stat(8'h04);
    cmd(`SEC_OP_STATUS_WRITE, 8'h00, 2);
    stat(8'h04);
    $display("status write test done");
    cmd(`SEC_OP_SET_LATCH);
    xfer(`SEC_OP_PAGE_WRITE, 16'h1800, 1, 99);
    stat(8'h06);
    xfer(`SEC_OP_PAGE_WRITE, 16'h17ff, 1, 99);
    // a page opcode while busy must not disturb the pending page
    xfer(`SEC_OP_PAGE_WRITE, 16'h17ff, 1, 99, 2);
    stat(8'h07);
    wait_done();
    exp_q.push_back({1'b1, d[0]});
    xfer(`SEC_OP_ARRAY_READ, 16'h17ff, 1, 3);
    cmd(`SEC_OP_SET_LATCH);
    srst = 1'b1;
    host.tick(5);
    srst = 1'b0;
    host.tick(5);
    stat(8'h04);
    $display("protect and reset test done");
    complete_run();
  end
endmodule
bind sec_eeprom_core sec_eeprom_core_chk chk (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_CS_N(I_CS_N),
  .I_SCK(I_SCK), .I_SI(I_SI), .I_WP_N(I_WP_N), .O_SO(O_SO), .O_SO_OE(O_SO_OE));
